// File: verilog/filt_defines.svh
`ifndef FILT_DEFINES_SVH
`define FILT_DEFINES_SVH

// Register byte addresses, one 32-bit word each
`define OFS_IRQ_ENABLE   8'h00
`define OFS_STATUS       8'h04
`define OFS_DALIGN       8'h08
`define OFS_COHER        8'h0C
`define OFS_STAGE_A      8'h10
`define OFS_STAGE_B      8'h14
`define OFS_HOLD_A       8'h18
`define OFS_HOLD_B       8'h1C

// Field positions
`define INT_EN_LSB       0
`define INT_EN_MSB       4
`define STAT_FLAG_LSB    3
`define STAT_FLAG_MSB    7
`define DALIGN_STAGE_LSB 0
`define DALIGN_HOLD_LSB  2

// Reset values
`define RST_IRQ_ENABLE   8'h00
`define RST_DALIGN       4'h0
`define RST_COHER        4'hA
`define RST_FLAGS        5'h00

`endif

// File: verilog/filt_pkg.sv
package filt_pkg;

  typedef enum logic [1:0] {
    KEY_LOW  = 2'b00,
    KEY_MID  = 2'b01,
    KEY_HIGH = 2'b10
  } key_sel_e;

  typedef enum logic [1:0] {
    WIDTH_8  = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_24 = 2'b10
  } sample_width_e;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_READ = 2'b01,
    HOST_CAPT = 2'b10
  } host_state_e;

endpackage

// File: verilog/filt_link_if.sv
`timescale 1ns/10ps
interface filt_link_if (
  input wire logic clock,  // System clock
  input wire logic rst_b   // Synchronous reset, active low
);
  logic [7:0]  addr;       // Register byte address
  logic        wr_en;      // Write strobe
  logic        rd_en;      // Read strobe
  logic [3:0]  byte_en;    // Byte lanes of a write
  logic [31:0] wdata;      // Write data
  logic [31:0] rdata;      // Read data, one cycle after rd_en
  logic        dma_req_a;  // Channel A holding full
  logic        dma_req_b;  // Channel B holding full
  logic        irq;        // Combined interrupt

  modport device (input clock, rst_b, addr, wr_en, rd_en, byte_en, wdata,
                  output rdata, dma_req_a, dma_req_b, irq);
  modport host   (input clock, rst_b, rdata, dma_req_a, dma_req_b, irq,
                  output addr, wr_en, rd_en, byte_en, wdata);
endinterface

// File: verilog/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,      // System clock
  input  wire logic             rst_b,      // Synchronous reset
  input  wire logic             in_valid,   // Word offered
  output      logic             in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Word in
  output      logic             out_valid,  // Word available
  input  wire logic             out_ready,  // Drain accepts
  output      logic [WIDTH-1:0] out_data    // Word out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty from pointers with a wrap bit
  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wr_ptr_next = wr_ptr_reg + (AW+1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
  end

  // Pointer and storage registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule // sample_fifo

// File: verilog/filt_device.sv
`timescale 1ns/10ps
`include "filt_defines.svh"
// What this block does
// - Interrupt is OR of enabled events
// - Enables 4..2 catch semaphore bit writes
// - Enables 1..0 catch new holding results
// - Polling reads status set by enabled events
// - Staging writable per byte lane, holding read as a whole word
// - Level DMA request per holding register
// - Alignment shift off after reset
// - Feeder enables shift for 16-bit samples
// - Key byte and burst size follow width
// - Converter reads start at low byte
// - Status cleared by one-write or holding read
// - Status shows which holding caused interrupt
// - Staging key-byte write starts filter pass
// - Shift maps bus 15:0 onto bits 23:8
module filt_device
  import filt_pkg::*;
(
  filt_link_if.device link,                 // Register and DMA port
  input  wire logic [2:0]  sem_set,        // Pulses: one written to semaphore bit
  input  wire logic        result_valid,   // Pulse: new filter result
  input  wire logic        result_chan,    // Result channel, 1 = B
  input  wire logic [23:0] result_data,    // Result sample
  input  wire logic [2:0]  dp_status,      // Datapath status bits
  output      logic        pass_start,     // Pulse: begin a filter pass
  output      logic        pass_chan,      // Channel of that pass
  output      logic [23:0] stage_a_data,   // Staging A contents
  output      logic [23:0] stage_b_data    // Staging B contents
);
  logic [7:0]  interrupt_enable_control_reg;   // Event enables
  logic [7:0]  interrupt_enable_control_next;  // Enables after this cycle
  logic [3:0]  dalign_reg, dalign_next;
  logic [3:0]  coher_reg, coher_next;
  logic [4:0]  flag_reg, flag_next;
  logic [23:0] stage_reg [2];
  logic [23:0] stage_next [2];
  logic [23:0] hold_reg [2];
  logic [23:0] hold_next [2];
  logic [1:0]  full_reg, full_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        start_reg, start_next;
  logic        chan_reg, chan_next;
  logic [4:0]  events, clear;
  logic [23:0] shifted;
  logic [2:0]  lanes;
  logic        ch;
  logic        wr_enable;    // Enable register write
  logic        wr_status;    // Status one-to-clear write
  logic        wr_dalign;    // Alignment register write
  logic        wr_coher;     // Key byte register write
  logic        wr_stage;     // Staging write, either channel
  logic        rd_hold;      // Holding read, either channel
  logic [1:0]  key_pos;      // Key byte of the addressed channel
  logic        key_hit;      // Write reaches the key byte
  logic [4:0]  enable_bits;  // Stored event enables

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.rdata     = rdata_reg;
  assign link.dma_req_a = full_reg[0];
  assign link.dma_req_b = full_reg[1];
  assign enable_bits    = interrupt_enable_control_reg[`INT_EN_MSB:`INT_EN_LSB];
  assign link.irq       = |(flag_reg & enable_bits);
  assign pass_start     = start_reg;
  assign pass_chan      = chan_reg;
  assign stage_a_data   = stage_reg[0];
  assign stage_b_data   = stage_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; bit 2 picks channel B for staging and holding alike
  always_comb begin
    ch        = link.addr[2];
    key_pos   = coher_reg[2*ch +: 2];
    wr_enable = link.wr_en && link.byte_en[0] && (link.addr == `OFS_IRQ_ENABLE);
    wr_status = link.wr_en && link.byte_en[0] && (link.addr == `OFS_STATUS);
    wr_dalign = link.wr_en && link.byte_en[0] && (link.addr == `OFS_DALIGN);
    wr_coher  = link.wr_en && link.byte_en[0] && (link.addr == `OFS_COHER);
    wr_stage  = link.wr_en && ((link.addr == `OFS_STAGE_A) || (link.addr == `OFS_STAGE_B));
    rd_hold   = link.rd_en && ((link.addr == `OFS_HOLD_A) || (link.addr == `OFS_HOLD_B));
  end

  // Event order matches enable bits: sem2..sem0, hold B, hold A
  always_comb begin
    events = {sem_set, result_valid && result_chan, result_valid && !result_chan};
    clear  = 5'h00;
    if (wr_status) begin
      clear = link.wdata[`STAT_FLAG_MSB:`STAT_FLAG_LSB];
    end
    if (rd_hold) begin
      clear[ch] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, reserved enable bits never stored
  always_comb begin
    interrupt_enable_control_next = interrupt_enable_control_reg;
    dalign_next                   = dalign_reg;
    coher_next                    = coher_reg;
    if (wr_enable) begin
      interrupt_enable_control_next = {3'b000, link.wdata[`INT_EN_MSB:`INT_EN_LSB]};
    end
    if (wr_dalign) begin
      dalign_next = link.wdata[3:0];
    end
    if (wr_coher) begin
      coher_next = link.wdata[3:0];
    end
  end

  // Configuration state
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      interrupt_enable_control_reg <= `RST_IRQ_ENABLE;
      dalign_reg                   <= `RST_DALIGN;
      coher_reg                    <= `RST_COHER;
    end else begin
      interrupt_enable_control_reg <= interrupt_enable_control_next;
      dalign_reg                   <= dalign_next;
      coher_reg                    <= coher_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging writes, moved up a byte when alignment is on
  always_comb begin
    stage_next = stage_reg;
    start_next = 1'b0;
    chan_next  = chan_reg;
    shifted    = link.wdata[23:0];
    lanes      = link.byte_en[2:0];
    if (dalign_reg[`DALIGN_STAGE_LSB + ch]) begin
      shifted = {link.wdata[15:0], 8'h00};
      lanes   = {link.byte_en[1:0], 1'b0};
    end
    // Unused key code 3 behaves as the high byte
    unique case (key_pos)
      2'h0:    key_hit = lanes[0];
      2'h1:    key_hit = lanes[1];
      default: key_hit = lanes[2];
    endcase
    if (wr_stage) begin
      for (int i = 0; i < 3; i++) begin
        if (lanes[i]) begin
          stage_next[ch][8*i +: 8] = shifted[8*i +: 8];
        end
      end
      // Pass starts only once the key byte has landed
      if (key_hit) begin
        start_next = 1'b1;
        chan_next  = ch;
      end
    end
  end

  // Staging state
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      stage_reg <= '{default: 24'h000000};
      start_reg <= 1'b0;
      chan_reg  <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      start_reg <= start_next;
      chan_reg  <= chan_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers, a new result wins over a read in the same cycle
  always_comb begin
    hold_next = hold_reg;
    full_next = full_reg;
    if (rd_hold) begin
      full_next[ch] = 1'b0;
    end
    if (result_valid) begin
      hold_next[result_chan] = result_data;
      full_next[result_chan] = 1'b1;
    end
  end

  // Holding state
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      hold_reg <= '{default: 24'h000000};
      full_reg <= 2'b00;
    end else begin
      hold_reg <= hold_next;
      full_reg <= full_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (link.rd_en) begin
      unique case (link.addr)
        `OFS_IRQ_ENABLE: rdata_next = {24'h000000, interrupt_enable_control_reg};
        `OFS_STATUS:     rdata_next = {24'h000000, flag_reg, dp_status};
        `OFS_DALIGN:     rdata_next = {28'h0000000, dalign_reg};
        `OFS_COHER:      rdata_next = {28'h0000000, coher_reg};
        `OFS_STAGE_A:    rdata_next = {8'h00, stage_reg[0]};
        `OFS_STAGE_B:    rdata_next = {8'h00, stage_reg[1]};
        `OFS_HOLD_A, `OFS_HOLD_B: begin
          if (dalign_reg[`DALIGN_HOLD_LSB + ch]) begin
            rdata_next = {16'h0000, hold_reg[ch][23:8]};
          end else begin
            rdata_next = {8'h00, hold_reg[ch]};
          end
        end
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: only enabled events set, a set beats a clear
  always_comb begin
    flag_next = (flag_reg & ~clear) | (events & enable_bits);
  end

  // Status flag register
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      flag_reg <= `RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule // filt_device

// File: verilog/filt_host.sv
`timescale 1ns/10ps
`include "filt_defines.svh"
module filt_host
  import filt_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  filt_link_if.host    link,          // Register and DMA port
  input  wire logic        cfg_valid,    // Register write offered
  output      logic        cfg_ready,    // Register write taken
  input  wire logic [7:0]  cfg_addr,     // Register address
  input  wire logic [7:0]  cfg_data,     // Register data, low byte
  input  wire logic        in_valid,     // Sample offered
  output      logic        in_ready,     // Sample taken
  input  wire logic        in_chan,      // Sample channel, 1 = B
  input  wire logic [23:0] in_data,      // Sample, little endian
  input  wire sample_width_e in_width,   // Sample width
  output      logic        out_valid,    // Result available
  input  wire logic        out_ready,    // Result accepted
  output      logic [24:0] out_data      // {channel, raw read word}
);
  host_state_e state_reg, state_next;
  logic [7:0]  addr_reg, addr_next;
  logic        wr_reg, wr_next;
  logic        rd_reg, rd_next;
  logic [3:0]  be_reg, be_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        chan_reg, chan_next;
  logic        fifo_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Bus outputs from flops
  assign link.addr    = addr_reg;
  assign link.wr_en   = wr_reg;
  assign link.rd_en   = rd_reg;
  assign link.byte_en = be_reg;
  assign link.wdata   = wdata_reg;

  // Results buffered toward the user
  sample_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (link.clock),
    .rst_b     (link.rst_b),
    .in_valid  (state_reg == HOST_CAPT),
    .in_ready  (fifo_ready),
    .in_data   ({chan_reg, link.rdata[23:0]}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: config, then drain holding, then feed staging
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    be_next    = be_reg;
    wdata_next = wdata_reg;
    chan_next  = chan_reg;
    cfg_ready  = 1'b0;
    in_ready   = 1'b0;
    unique case (state_reg)
      HOST_IDLE: begin
        if (cfg_valid) begin
          cfg_ready  = 1'b1;
          wr_next    = 1'b1;
          addr_next  = cfg_addr;
          be_next    = 4'h1;
          wdata_next = {24'h000000, cfg_data};
        end else if ((link.dma_req_a || link.dma_req_b) && fifo_ready) begin
          chan_next  = !link.dma_req_a;
          rd_next    = 1'b1;
          addr_next  = link.dma_req_a ? `OFS_HOLD_A : `OFS_HOLD_B;
          state_next = HOST_READ;
        end else if (in_valid) begin
          in_ready   = 1'b1;
          wr_next    = 1'b1;
          addr_next  = in_chan ? `OFS_STAGE_B : `OFS_STAGE_A;
          // Low byte in lane 0, burst sized by width
          unique case (in_width)
            WIDTH_8: begin
              be_next    = 4'h1;
              wdata_next = {24'h000000, in_data[7:0]};
            end
            WIDTH_16: begin
              be_next    = 4'h3;
              wdata_next = {16'h0000, in_data[15:0]};
            end
            default: begin
              be_next    = 4'hF;
              wdata_next = {8'h00, in_data};
            end
          endcase
        end
      end
      HOST_READ: state_next = HOST_CAPT;
      HOST_CAPT: state_next = HOST_IDLE;
      default:   state_next = HOST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge link.clock) begin
    if (!link.rst_b) begin
      state_reg <= HOST_IDLE;
      addr_reg  <= 8'h00;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      be_reg    <= 4'h0;
      wdata_reg <= 32'h00000000;
      chan_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      be_reg    <= be_next;
      wdata_reg <= wdata_next;
      chan_reg  <= chan_next;
    end
  end
endmodule // filt_host

// File: test/filt_link_properties.sv
`timescale 1ns/10ps
`include "filt_defines.svh"
module filt_link_properties (
  input wire logic        clock,      // System clock
  input wire logic        rst_b,      // Reset, active low
  input wire logic [7:0]  addr,       // Byte address
  input wire logic        wr_en,      // Write strobe
  input wire logic        rd_en,      // Read strobe
  input wire logic [3:0]  byte_en,    // Write lanes
  input wire logic [31:0] wdata,      // Write data
  input wire logic [31:0] rdata,      // Read data
  input wire logic        dma_req_a,  // Channel A request
  input wire logic        dma_req_b,  // Channel B request
  input wire logic        irq         // Interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [4:0] enable_reg;
  logic [4:0] enable_next;
  ////////////////////////////////////////
  // Mirror of the enable field
  always_comb begin
    enable_next = enable_reg;
    if (!rst_b) enable_next = 5'h00;
    else if (wr_en && byte_en[0] && addr == `OFS_IRQ_ENABLE) enable_next = wdata[4:0];
  end
  always_ff @(posedge clock) begin
    enable_reg <= enable_next;
  end
  ////////////////////////////////////////
  // Interrupt follows the enabled sources
  property p_irq_masked;
    wr_en && byte_en[0] && addr == `OFS_IRQ_ENABLE && wdata[4:0] == 5'h00 |=> !irq [*2];
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all enables clear");
  property p_irq_cause;
    irq |-> enable_reg != 5'h00;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without any enable");
  property p_hold_a_irq;
    $rose(dma_req_a) && enable_reg[0] |-> irq;
  endproperty
  a_hold_a_irq: assert property (p_hold_a_irq) else $error("no irq for result A");
  property p_hold_b_irq;
    $rose(dma_req_b) && enable_reg[1] |-> irq;
  endproperty
  a_hold_b_irq: assert property (p_hold_b_irq) else $error("no irq for result B");
  // Requests stay up until their holding register is read
  property p_dma_a_held;
    $fell(dma_req_a) && $past(rst_b) |-> $past(rd_en) && $past(addr) == `OFS_HOLD_A;
  endproperty
  a_dma_a_held: assert property (p_dma_a_held) else $error("request A dropped unread");
  property p_dma_b_held;
    $fell(dma_req_b) && $past(rst_b) |-> $past(rd_en) && $past(addr) == `OFS_HOLD_B;
  endproperty
  a_dma_b_held: assert property (p_dma_b_held) else $error("request B dropped unread");
  property p_read_a_clears;
    rd_en && addr == `OFS_HOLD_A |=> !dma_req_a;
  endproperty
  a_read_a_clears: assert property (p_read_a_clears) else $error("request A after read");
  property p_read_b_clears;
    rd_en && addr == `OFS_HOLD_B |=> !dma_req_b;
  endproperty
  a_read_b_clears: assert property (p_read_b_clears) else $error("request B after read");
endmodule  // filt_link_properties

// File: test/filt_irq_dma_interface_test.sv
`timescale 1ns/10ps
`include "filt_defines.svh"
module filt_irq_dma_interface_test
  import filt_pkg::*;
;
  logic          clock = 1'b0;
  logic          rst_b = 1'b0;
  logic [2:0]    sem_set = 3'h0;
  logic          result_valid = 1'b0;
  logic          result_chan = 1'b0;
  logic [23:0]   result_data = 24'h000000;
  logic          pass_start, pass_chan, cfg_ready, in_ready, out_valid;
  logic [23:0]   stage_a_data, stage_b_data;
  logic          cfg_valid = 1'b0;
  logic [7:0]    cfg_addr = 8'h00;
  logic [7:0]    cfg_data = 8'h00;
  logic          in_valid = 1'b0;
  logic          in_chan = 1'b0;
  logic [23:0]   in_data = 24'h000000;
  sample_width_e in_width = WIDTH_24;
  logic          out_ready = 1'b0;
  logic [24:0]   out_data, got;
  int            err_total = 0;
  int            checked = 0;
  ////////////////////////////////////////
  // Clock, ends and checker
  always #5 clock = ~clock;
  filt_link_if u_filt_link_if (.clock(clock), .rst_b(rst_b));
  filt_device u_filt_device (.link(u_filt_link_if), .sem_set(sem_set), .result_valid(result_valid),
    .result_chan(result_chan), .result_data(result_data), .dp_status(3'h0), .pass_start(pass_start),
    .pass_chan(pass_chan), .stage_a_data(stage_a_data), .stage_b_data(stage_b_data));
  filt_host #(.FIFO_DEPTH(16)) u_filt_host (.link(u_filt_link_if), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .in_valid(in_valid),
    .in_ready(in_ready), .in_chan(in_chan), .in_data(in_data), .in_width(in_width),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  filt_link_properties u_filt_link_properties (.clock(clock), .rst_b(rst_b),
    .addr(u_filt_link_if.addr), .wr_en(u_filt_link_if.wr_en), .rd_en(u_filt_link_if.rd_en),
    .byte_en(u_filt_link_if.byte_en), .wdata(u_filt_link_if.wdata), .rdata(u_filt_link_if.rdata),
    .dma_req_a(u_filt_link_if.dma_req_a), .dma_req_b(u_filt_link_if.dma_req_b),
    .irq(u_filt_link_if.irq));
  ////////////////////////////////////////
  // Reporting
  task test_done;
    $display("checked %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic timed_out(input string what);
    err_total++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    test_done();
  endtask
  task automatic chk_bit(input logic got_v, input logic exp);
    checked++;
    if (got_v !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got_v, exp);
    end
  endtask
  task automatic chk_word(input logic [24:0] got_v, input logic [24:0] exp);
    checked++;
    if (got_v !== exp) begin
      err_total++;
      $display("mismatch at %0t: word %h, expected %h", $time, got_v, exp);
    end
  endtask
  ////////////////////////////////////////
  // Drivers, all changing inputs 1 ns after the edge
  task step;
    @(posedge clock);
    #1;
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    step;
    cfg_valid = 1'b1;
    cfg_addr = a;
    cfg_data = d;
    n = 0;
    do begin @(posedge clock); n++; end while (cfg_ready !== 1'b1 && n < 50);
    if (cfg_ready !== 1'b1) timed_out("cfg");
    #1 cfg_valid = 1'b0;
  endtask
  task automatic send(input logic c, input logic [23:0] d, input sample_width_e w);
    int n;
    step;
    in_valid = 1'b1;
    in_chan = c;
    in_data = d;
    in_width = w;
    n = 0;
    do begin @(posedge clock); n++; end while (in_ready !== 1'b1 && n < 50);
    if (in_ready !== 1'b1) timed_out("sample");
    #1 in_valid = 1'b0;
    for (n = 0; n < 20 && pass_start !== 1'b1; n++) @(posedge clock);
    if (pass_start !== 1'b1) timed_out("pass");
    chk_bit(pass_chan, c);
  endtask
  task automatic get_out(output logic [24:0] d);
    int n;
    step;
    out_ready = 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (out_valid !== 1'b1 && n < 50);
    if (out_valid !== 1'b1) timed_out("result");
    d = out_data;
    #1 out_ready = 1'b0;
  endtask
  task automatic pulse_result(input logic c, input logic [23:0] d);
    step;
    result_chan = c;
    result_data = d;
    result_valid = 1'b1;
    step;
    result_valid = 1'b0;
  endtask
  task automatic pulse_sem(input int i);
    step;
    sem_set = 3'h1 << i;
    step;
    sem_set = 3'h0;
  endtask
  task automatic wait_irq(input logic exp);
    int n;
    for (n = 0; n < 20 && u_filt_link_if.irq !== exp; n++) step;
    if (n == 20) timed_out("irq");
    chk_bit(u_filt_link_if.irq, exp);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task test_stage;
    send(1'b0, 24'h123456, WIDTH_24);
    chk_word({1'b0, stage_a_data}, {1'b0, 24'h123456});
    send(1'b1, 24'h654321, WIDTH_24);
    chk_word({1'b0, stage_b_data}, {1'b0, 24'h654321});
    cfg_write(`OFS_DALIGN, 8'h01);
    cfg_write(`OFS_COHER, 8'h09);
    send(1'b0, 24'h00BEEF, WIDTH_16);
    chk_word({9'h000, stage_a_data[23:8]}, {9'h000, 16'hBEEF});
    cfg_write(`OFS_DALIGN, 8'h00);
    cfg_write(`OFS_COHER, 8'h08);
    send(1'b0, 24'h00005A, WIDTH_8);
    chk_word({17'h00000, stage_a_data[7:0]}, {17'h00000, 8'h5A});
    cfg_write(`OFS_COHER, 8'h0A);
    $display("test_stage done");
  endtask
  task test_irq;
    cfg_write(`OFS_IRQ_ENABLE, 8'hFF);
    step;
    chk_word({17'h00000, u_filt_device.interrupt_enable_control_reg}, {17'h00000, 8'h1F});
    for (int i = 0; i < 3; i++) begin
      pulse_sem(i);
      wait_irq(1'b1);
      chk_word({20'h00000, u_filt_device.flag_reg}, {20'h00000, 5'h04 << i});
      cfg_write(`OFS_STATUS, 8'h20 << i);
      wait_irq(1'b0);
    end
    cfg_write(`OFS_IRQ_ENABLE, 8'h00);
    pulse_sem(0);
    step;
    chk_bit(u_filt_link_if.irq, 1'b0);
    $display("test_irq done");
  endtask
  task test_hold;
    cfg_write(`OFS_IRQ_ENABLE, 8'h03);
    pulse_result(1'b0, 24'hABCDEF);
    wait_irq(1'b1);
    chk_word({20'h00000, u_filt_device.flag_reg}, {20'h00000, 5'h01});
    get_out(got);
    chk_word(got, {1'b0, 24'hABCDEF});
    wait_irq(1'b0);
    chk_bit(u_filt_link_if.dma_req_a, 1'b0);
    cfg_write(`OFS_DALIGN, 8'h04);
    pulse_result(1'b0, 24'h13579B);
    get_out(got);
    chk_word(got, {1'b0, 24'h001357});
    cfg_write(`OFS_DALIGN, 8'h00);
    $display("test_hold done");
  endtask
  task test_fill;
    cfg_write(`OFS_IRQ_ENABLE, 8'h02);
    for (int i = 0; i < 17; i++) begin
      pulse_result(1'b1, 24'h000100 + 24'(i));
      repeat (6) step;
    end
    chk_bit(u_filt_link_if.dma_req_b, 1'b1);
    for (int i = 0; i < 17; i++) begin
      get_out(got);
      chk_word(got, {1'b1, 24'h000100 + 24'(i)});
    end
    chk_bit(u_filt_link_if.dma_req_b, 1'b0);
    $display("test_fill done");
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    chk_bit(u_filt_link_if.irq, 1'b0);
    chk_word({21'h000000, u_filt_device.dalign_reg}, {21'h000000, 4'h0});
    test_stage();
    test_irq();
    test_hold();
    test_fill();
    test_done();
  end
endmodule  // filt_irq_dma_interface_test
